/* File: design/fadc_regs.vh */
`ifndef FADC_REGS_VH
`define FADC_REGS_VH

// Comparator count and output word width.
`define FADC_NUM_CMP 15
`define FADC_WORD_W 4
// Field position of the top output bit.
`define FADC_MSB_POS 3
// Width of the low-order group governed by the lower invert control.
`define FADC_LSB_GRP_W 3
// Reset value of the output word and of the latched comparators.
`define FADC_WORD_RST 4'h0
`define FADC_THERM_RST 15'h0000
// Buffer depth in words.
`define FADC_FIFO_DEPTH 16
// Shortest strobe period allowed, in ns (25 Msps).
`define FADC_MIN_STROBE_NS 40
`define FADC_CLK_NS 10
`define FADC_MIN_STROBE_CYC ((`FADC_MIN_STROBE_NS + `FADC_CLK_NS - 1) / `FADC_CLK_NS)
// Strobe edges needed before the output word is defined.
`define FADC_WARMUP_EDGES 2'h2

`endif

/* File: design/fadc_fifo.v */
`default_nettype none

module fadc_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset.
    input wire core_clk,
    input wire rst_n,
    // Fill side.
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side.
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;
    integer i;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (do_wr) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* File: design/fadc_encoder.v */
// Notes on behaviour
// [RL1] Fifteen comparator results arrive as a thermometer code into the encoder.
// [RL2] A comparator reads one when the input lies above its reference, zero when below.
// [RL3] The thermometer code is encoded to binary or offset two's complement, optionally inverted.
// [RL4] The two format inputs are static settings held by the driving party.
// [RL5] The output word comes from a register that holds its value between updates.
// [RL6] Both format inputs are active low: low inverts the bits they govern.
// [RL7] The MSB control acts on the top bit only; the lower control on the three low bits.
// [RL8] The two controls select true or inverted binary or offset two's complement.
// [RL9] True binary gives 0000 at the most positive step and 1111 at the most negative.
// [RL10] Comparator states are latched on each rising edge of the sample strobe.
// [RL11] The encoded sample reaches the output register on the next rising strobe edge.
// [RL12] An in-range input yields a code from 0 to 15.
// [RL13] Inputs beyond the range saturate to the full-scale code at that end.
// [RL14] The driving party issues strobes no faster than 25 Msps.
// [RL15] Each result is a 4-bit parallel word.
// [RL16] The sample strobe alone controls conversion.
// [RL17] The output word is undefined until two rising strobe edges have passed.
`include "fadc_regs.vh"
`default_nettype none

module fadc_encoder #(
    parameter NUM_CMP = `FADC_NUM_CMP,
    parameter WORD_W = `FADC_WORD_W,
    parameter FIFO_DEPTH = `FADC_FIFO_DEPTH,
    parameter MIN_STROBE_CYC = `FADC_MIN_STROBE_CYC
) (
    // Clock and reset.
    input wire core_clk,
    input wire rst_n,
    // Comparator results, bit k set when the input lies above reference k.
    input wire [NUM_CMP-1:0] cmp_above,
    // Format controls, active low.
    input wire msb_invert_n,
    input wire lsb_group_invert_n,
    // Sample strobe.
    input wire sample_strobe,
    // Output word register.
    output reg out_bit_msb,
    output reg out_bit_2,
    output reg out_bit_3,
    output reg out_bit_lsb,
    output reg out_word_valid,
    // Buffered sample stream.
    output reg stream_valid,
    input wire stream_ready,
    output reg [WORD_W-1:0] stream_data,
    output reg stream_overflow,
    output reg strobe_too_fast
);

    reg strobe_prev;
    reg [NUM_CMP-1:0] therm_latched;
    reg [1:0] warmup;
    reg [7:0] gap_cnt;
    wire strobe_rise;
    wire [WORD_W-1:0] enc_word;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [WORD_W-1:0] fifo_out_data;
    wire take_out;

    // Counts set comparators, so a bubble-free code maps straight to the step.
    function [WORD_W-1:0] therm_count;
        input [NUM_CMP-1:0] t;
        integer k;
        reg [WORD_W:0] acc;
        begin
            acc = {(WORD_W+1){1'b0}};
            for (k = 0; k < NUM_CMP; k = k + 1) begin
                acc = acc + {{WORD_W{1'b0}}, t[k]};
            end
            therm_count = acc[WORD_W-1:0];
        end
    endfunction

    // Applies the format; true binary is most positive input at code zero.
    function [WORD_W-1:0] apply_format;
        input [WORD_W-1:0] level;
        input minv_n;
        input linv_n;
        reg [WORD_W-1:0] tb;
        begin
            tb = ~level; // [RL9] [RL12] [RL13]
            apply_format = {tb[`FADC_MSB_POS] ^ ~minv_n,
                            tb[`FADC_LSB_GRP_W-1:0] ^ {`FADC_LSB_GRP_W{~linv_n}}}; // [RL6] [RL7] [RL8]
        end
    endfunction

    // Fifteen comparators cover sixteen steps; all on is the most positive code 0000
    // once inverted. Out-of-range inputs light all or none, so they saturate.
    assign enc_word = apply_format(therm_count(therm_latched), msb_invert_n,
                                   lsb_group_invert_n); // [RL2] [RL3] [RL15]
    assign strobe_rise = sample_strobe && !strobe_prev; // [RL16]
    assign take_out = fifo_out_valid && (!stream_valid || stream_ready);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_prev <= 1'b0;
            therm_latched <= `FADC_THERM_RST;
            out_bit_msb <= 1'b0;
            out_bit_2 <= 1'b0;
            out_bit_3 <= 1'b0;
            out_bit_lsb <= 1'b0;
            warmup <= 2'h0;
            out_word_valid <= 1'b0;
            gap_cnt <= 8'h00;
            strobe_too_fast <= 1'b0;
        end else begin
            strobe_prev <= sample_strobe;
            if (gap_cnt != 8'hff) begin
                gap_cnt <= gap_cnt + 8'h01;
            end
            if (strobe_rise) begin
                therm_latched <= cmp_above; // [RL1] [RL10]
                {out_bit_msb, out_bit_2, out_bit_3, out_bit_lsb} <= enc_word; // [RL11] [RL5]
                if (warmup != `FADC_WARMUP_EDGES) begin
                    warmup <= warmup + 2'h1;
                end
                out_word_valid <= (warmup >= `FADC_WARMUP_EDGES - 2'h1); // [RL17]
                gap_cnt <= 8'h01;
                if (warmup != 2'h0 && gap_cnt < MIN_STROBE_CYC[7:0]) begin
                    strobe_too_fast <= 1'b1; // [RL14]
                end
            end
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stream_valid <= 1'b0;
            stream_data <= `FADC_WORD_RST;
        end else if (take_out) begin
            stream_valid <= 1'b1;
            stream_data <= fifo_out_data;
        end else if (stream_ready) begin
            stream_valid <= 1'b0;
        end
    end

    // Each defined output word, captured one cycle after its strobe edge, is queued unless the buffer is full.
    reg push;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            push <= 1'b0;
            stream_overflow <= 1'b0;
        end else begin
            push <= strobe_rise && (warmup >= `FADC_WARMUP_EDGES - 2'h1);
            // A defined word that meets a full buffer is lost, and the loss is kept.
            if (push && !fifo_in_ready) begin
                stream_overflow <= 1'b1;
            end
        end
    end

    fadc_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH),
        .AW($clog2(FIFO_DEPTH))
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({out_bit_msb, out_bit_2, out_bit_3, out_bit_lsb}),
        .out_valid(fifo_out_valid),
        .out_ready(take_out),
        .out_data(fifo_out_data)
    );

endmodule

`default_nettype wire

/* File: test/fadc_props.sv */
`default_nettype none
module fadc_props #(parameter int NUM_CMP = 15, parameter int WORD_W = 4) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Stimulus.
    input wire logic [NUM_CMP-1:0] cmp_above,
    input wire logic msb_invert_n,
    input wire logic lsb_group_invert_n,
    input wire logic sample_strobe,
    input wire logic stream_ready,
    // Results.
    input wire logic out_bit_msb,
    input wire logic out_bit_2,
    input wire logic out_bit_3,
    input wire logic out_bit_lsb,
    input wire logic out_word_valid,
    input wire logic stream_valid,
    input wire logic [WORD_W-1:0] stream_data,
    input wire logic stream_overflow,
    input wire logic strobe_too_fast
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_s;
    logic [1:0] nr;
    logic [NUM_CMP-1:0] lat;
    wire logic [3:0] word = {out_bit_msb, out_bit_2, out_bit_3, out_bit_lsb};
    function automatic logic [3:0] enc(logic [NUM_CMP-1:0] t);
        return (4'hf - 4'($countones(t))) ^ {~msb_invert_n, {3{~lsb_group_invert_n}}};
    endfunction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_s <= 1'h0;
            nr <= 2'h0;
            lat <= '0;
        end else begin
            prev_s <= sample_strobe;
            if (sample_strobe && !prev_s) begin
                lat <= cmp_above;
                nr <= (nr == 2'h2) ? nr : nr + 2'h1;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rise;
        !sample_strobe ##1 sample_strobe;
    endsequence
    word_hold_a: assert property (!(sample_strobe && !prev_s) |=> $stable(word))
        else $error("output word moved without a strobe rise");
    enc_code_a: assert property (s_rise ##0 nr != 2'h0 |=> word == enc($past(lat)))
        else $error("output word differs from the previous sample code");
    full_scale_a: assert property (s_rise ##0 (nr != 2'h0 && &lat && msb_invert_n
        && lsb_group_invert_n) |=> word == 4'h0)
        else $error("top step not coded as zero");
    word_valid_a: assert property (out_word_valid == (nr == 2'h2))
        else $error("word valid flag not tied to the second strobe rise");
    too_fast_a: assert property (s_rise ##[1:2] s_rise |=> strobe_too_fast)
        else $error("close strobe rises not flagged");
    fast_sticky_a: assert property (strobe_too_fast |=> strobe_too_fast)
        else $error("rate flag cleared");
    ovf_sticky_a: assert property (stream_overflow |=> stream_overflow)
        else $error("overflow flag cleared");
    stream_hold_a: assert property (stream_valid && !stream_ready |=>
        stream_valid && $stable(stream_data))
        else $error("stream word dropped while stalled");
endmodule
bind fadc_encoder fadc_props #(.NUM_CMP(NUM_CMP), .WORD_W(WORD_W)) u_props (.core_clk, .rst_n,
    .cmp_above, .msb_invert_n, .lsb_group_invert_n, .sample_strobe, .stream_ready, .out_bit_msb,
    .out_bit_2, .out_bit_3, .out_bit_lsb, .out_word_valid, .stream_valid, .stream_data,
    .stream_overflow, .strobe_too_fast);
`default_nettype wire

/* File: test/fadc_sink.sv */
`default_nettype none
module fadc_sink (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Pacing controls.
    input wire logic fast,
    input wire logic stall,
    // Strobe and stream acceptance.
    output logic sample_strobe,
    output logic stream_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int pseed = 32'h2d49;
    logic [2:0] cnt;
    // A six-cycle period keeps the 40 ns floor; fast mode breaks it on purpose.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            sample_strobe <= 1'h0;
            stream_ready <= 1'h0;
        end else begin
            cnt <= (cnt >= (fast ? 3'h1 : 3'h5)) ? 3'h0 : cnt + 3'h1;
            sample_strobe <= (cnt < (fast ? 3'h1 : 3'h3));
            stream_ready <= !stall && (fast || $random(pseed) % 2 != 0);
        end
    end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch at %0t: %h vs %h", $time, a, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n = 0, msb_invert_n = 1, lsb_group_invert_n = 1, fast = 0, stall = 0;
    logic [14:0] cmp_above = '0;
    wire logic sample_strobe, stream_ready, stream_valid, stream_overflow, strobe_too_fast;
    wire logic [3:0] stream_data;
    int err_count = 0, n_tests = 0, seed = 32'h2d49;
    logic [3:0] q[$];
    logic [14:0] held;
    logic have = 0, prev = 0;
    logic [3:0] exp_w;
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    fadc_encoder DUT (.core_clk, .rst_n, .cmp_above, .msb_invert_n, .lsb_group_invert_n,
        .sample_strobe, .out_bit_msb(), .out_bit_2(), .out_bit_3(), .out_bit_lsb(),
        .out_word_valid(), .stream_valid, .stream_ready, .stream_data, .stream_overflow,
        .strobe_too_fast);
    fadc_sink u_sink (.core_clk, .rst_n, .fast, .stall, .sample_strobe, .stream_ready);
    function automatic logic [3:0] tenc(logic [14:0] t);
        return (4'hf - 4'($countones(t))) ^ {~msb_invert_n, {3{~lsb_group_invert_n}}};
    endfunction
    always @(posedge core_clk) begin
        if (!rst_n) begin
            q.delete();
            have <= 0;
        end else if (sample_strobe && !prev) begin
            if (have) q.push_back(tenc(held));
            held <= cmp_above;
            have <= 1;
        end
        prev <= rst_n & sample_strobe;
    end
    always @(posedge core_clk)
        if (rst_n && stream_valid && stream_ready) begin
            exp_w = q.size() ? q.pop_front() : 4'hx;
            `CHK(stream_data, exp_w)
        end
    task automatic run(int cycles);
        int r;
        logic [3:0] n;
        repeat (cycles) begin
            @(posedge core_clk);
            r = $random(seed);
            n = r[4] ? {4{r[0]}} : r[3:0];
            cmp_above <= 15'((16'h1 << n) - 16'h1);
        end
    endtask
    task automatic summarize;
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        for (int f = 0; f < 4; f++) begin
            rst_n <= 0;
            {msb_invert_n, lsb_group_invert_n} <= 2'(f);
            repeat (2) @(posedge core_clk);
            rst_n <= 1;
            run(200);
        end
        `CHK(strobe_too_fast, 1'h0)
        fast <= 1;
        run(40);
        `CHK(strobe_too_fast, 1'h1)
        fast <= 0;
        stall <= 1;
        run(200);
        `CHK(stream_overflow, 1'h1)
        summarize();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
